// File: root_port_pkg.sv
// Shared constants and types for the root-port error and power-event register block
package root_port_pkg;

   // ==========================================================
   // Register indexes (byte address is four times the index)
   localparam int BUS_ADDR_W = 10;
   localparam logic [7:0] IDX_CONTROL = 8'h1c;
   localparam logic [7:0] IDX_CAPS = 8'h1e;
   localparam logic [7:0] IDX_STATUS = 8'h20;
   localparam logic [9:0] ADDR_CONTROL = {IDX_CONTROL, 2'h0};
   localparam logic [9:0] ADDR_CAPS = {IDX_CAPS, 2'h0};
   localparam logic [9:0] ADDR_STATUS = {IDX_STATUS, 2'h0};

   // ==========================================================
   // Control field positions and reset value
   localparam int CTL_W = 5;
   localparam int CTL_SE_COR = 0;
   localparam int CTL_SE_NONFATAL = 1;
   localparam int CTL_SE_FATAL = 2;
   localparam int CTL_PME_IE = 3;
   localparam int CTL_CRS_VIS = 4;
   localparam logic [4:0] CONTROL_RESET = 5'h00;

   // ==========================================================
   // Capability and status field positions
   localparam int CAP_CRS_VIS = 0;
   localparam int RID_W = 16;
   localparam int STS_RID_LSB = 0;
   localparam int STS_PME = 16;
   localparam int STS_PENDING = 17;
   localparam logic [15:0] RID_RESET = 16'h0000;

   // ==========================================================
   // Error severities, one bit each in a severity vector
   localparam int SEV_W = 3;
   localparam int SEV_COR = 0;
   localparam int SEV_NONFATAL = 1;
   localparam int SEV_FATAL = 2;

   // ==========================================================
   // Bus timing and answers
   localparam int BUS_WAIT_CYCLES = 1;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_DECODEERROR = 2'h3;
   localparam logic [31:0] READ_UNMAPPED = 32'h0000_0000;

   // ==========================================================
   // State machines
   typedef enum logic [1:0] {
      BUS_IDLE = 2'b01,
      BUS_ACK = 2'b10
   } bus_state_t;

   typedef enum logic [1:0] {
      PME_IDLE = 2'b01,
      PME_FETCH = 2'b10
   } pme_state_t;

endpackage

// File: pme_rid_mem.sv
// Small queue memory for pending power-event requester identities
`timescale 1ns/100ps
module pme_rid_mem #(
   parameter int DEPTH = 4,
   parameter int AW = 2,
   parameter int W = 16
) (
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic wr_en,
   input wire logic [AW-1:0] wr_addr,
   input wire logic [W-1:0] wr_data,
   input wire logic rd_en,
   input wire logic [AW-1:0] rd_addr,
   output logic [W-1:0] rd_data
);
   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [W-1:0] rdata;
   } mem_state_t;

   mem_state_t cur;
   mem_state_t next_cur;

   // Write and registered read; a read returns the value before a same-edge write
   always_comb begin
      next_cur = cur;
      if (wr_en) begin
         next_cur.mem[wr_addr] = wr_data;
      end
      if (rd_en) begin
         next_cur.rdata = cur.mem[rd_addr];
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         cur <= '0;
      end else begin
         cur <= next_cur;
      end
   end

   assign rd_data = cur.rdata;
endmodule

// File: err_severity_gate.sv
// Severity-gated system error generation from hierarchy, port and integrated endpoints
`timescale 1ns/100ps
module err_severity_gate #(
   parameter bit EVENT_COLLECTOR = 1'b0
) (
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic [root_port_pkg::SEV_W-1:0] enable,
   input wire logic [root_port_pkg::SEV_W-1:0] hier_err,
   input wire logic [root_port_pkg::SEV_W-1:0] port_err,
   input wire logic [root_port_pkg::SEV_W-1:0] rcie_err,
   output logic system_error,
   output logic [root_port_pkg::SEV_W-1:0] system_error_sev
);
   import root_port_pkg::*;

   typedef struct packed {
      logic sys_err;
      logic [SEV_W-1:0] sev;
   } gate_state_t;

   gate_state_t cur;
   gate_state_t next_cur;
   logic [SEV_W-1:0] seen;

   // Any source of a severity counts; integrated endpoints only in the collector build
   always_comb begin
      next_cur = cur;
      seen = hier_err | port_err | (EVENT_COLLECTOR ? rcie_err : '0);
      next_cur.sev = seen & enable;
      next_cur.sys_err = |(seen & enable);
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         cur <= '0;
      end else begin
         cur <= next_cur;
      end
   end

   assign system_error = cur.sys_err;
   assign system_error_sev = cur.sev;
endmodule

// File: root_port_error_pme_control.sv
// Root-port control, capability and power-event status registers behind an Avalon-MM slave
//
// The implementer's own choice: the Avalon-MM interface to the registers.
`timescale 1ns/100ps
module root_port_error_pme_control #(
   parameter bit CRS_SUPPORTED = 1'b1,
   parameter bit EVENT_COLLECTOR = 1'b0,
   parameter int PME_DEPTH = 4
) (
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic [root_port_pkg::BUS_ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic [1:0] avs_response,
   output logic avs_waitrequest,
   input wire logic [root_port_pkg::SEV_W-1:0] hier_err,
   input wire logic [root_port_pkg::SEV_W-1:0] port_err,
   input wire logic [root_port_pkg::SEV_W-1:0] rcie_err,
   output logic system_error,
   output logic [root_port_pkg::SEV_W-1:0] system_error_sev,
   input wire logic pme_msg_valid,
   input wire logic [root_port_pkg::RID_W-1:0] pme_msg_rid,
   output logic pme_dropped,
   output logic pme_interrupt,
   input wire logic crs_cpl_valid,
   output logic crs_to_software,
   output logic crs_retry_internal
);
   import root_port_pkg::*;

   // ==========================================================
   // Types and state
   // Pointers wrap at the depth; the count has a spare bit to tell full from empty
   localparam int AW = (PME_DEPTH > 1) ? $clog2(PME_DEPTH) : 1;
   localparam logic [AW:0] QUEUE_FULL = (AW+1)'(PME_DEPTH);
   localparam logic [AW-1:0] QUEUE_LAST = AW'(PME_DEPTH - 1);

   // Block state outside the error gate and queue memory in one register image
   typedef struct packed {
      bus_state_t bus;
      logic [31:0] rdata;
      logic [1:0] resp;
      logic [CTL_W-1:0] ctl;
      logic pme_status;
      logic [RID_W-1:0] pme_rid;
      pme_state_t pme;
      logic [AW-1:0] head;
      logic [AW-1:0] tail;
      logic [AW:0] count;
      logic pme_irq;
      logic pme_drop;
      logic crs_sw;
      logic crs_retry;
      logic out_of_reset;
   } state_t;

   // Registered image and its next value
   state_t cur;
   state_t next_cur;

   // Terms shared by the bus slave, the queue and the checks
   logic req;
   logic wr_now;
   logic w1c;
   logic pending;
   logic direct_load;
   logic push;
   logic fetch_start;
   logic fetch_done;
   logic [RID_W-1:0] mem_rdata;

   // Address match, shared by the read mux and the write decode
   function automatic logic hit(input logic [BUS_ADDR_W-1:0] a, input logic [BUS_ADDR_W-1:0] reg_addr);
      hit = (a[BUS_ADDR_W-1:2] == reg_addr[BUS_ADDR_W-1:2]);
   endfunction

   // Unmapped words answer with a decode error and read as zero
   function automatic logic mapped(input logic [BUS_ADDR_W-1:0] a);
      mapped = hit(a, ADDR_CONTROL) | hit(a, ADDR_CAPS) | hit(a, ADDR_STATUS);
   endfunction

   // ==========================================================
   // Bus handshake terms
   // One wait state: the request is seen, the answer is loaded, then released
   assign req = avs_read | avs_write;
   assign avs_waitrequest = req & (cur.bus != BUS_ACK);
   assign wr_now = avs_write & (cur.bus == BUS_ACK);
   assign w1c = wr_now & hit(avs_address, ADDR_STATUS) & avs_byteenable[2]
      & avs_writedata[STS_PME];

   // ==========================================================
   // Power-event queue terms
   // A fresh event bypasses the queue only when nothing is waiting, keeping order
   assign pending = cur.pme_status & (cur.count != '0);
   assign direct_load = pme_msg_valid & ~cur.pme_status & (cur.count == '0)
      & (cur.pme == PME_IDLE);
   assign push = pme_msg_valid & ~direct_load & (cur.count != QUEUE_FULL);
   assign fetch_start = (cur.pme == PME_IDLE) & ~cur.pme_status & (cur.count != '0);
   assign fetch_done = (cur.pme == PME_FETCH);

   // Queue memory reads through a register, so a fetch costs one extra cycle
   pme_rid_mem #(
      .DEPTH(PME_DEPTH),
      .AW(AW),
      .W(RID_W)
   ) u_queue (
      .mclk(mclk),
      .arst_n(arst_n),
      .wr_en(push),
      .wr_addr(cur.tail),
      .wr_data(pme_msg_rid),
      .rd_en(fetch_start),
      .rd_addr(cur.head),
      .rd_data(mem_rdata)
   );

   // Registered gate: system error lags its cause by one edge
   err_severity_gate #(
      .EVENT_COLLECTOR(EVENT_COLLECTOR)
   ) u_err_gate (
      .mclk(mclk),
      .arst_n(arst_n),
      .enable(cur.ctl[CTL_SE_FATAL:CTL_SE_COR]),
      .hier_err(hier_err),
      .port_err(port_err),
      .rcie_err(rcie_err),
      .system_error(system_error),
      .system_error_sev(system_error_sev)
   );

   // ==========================================================
   // Next-state logic
   always_comb begin
      next_cur = cur;
      next_cur.out_of_reset = 1'b1;

      // Bus slave: read data captured in the wait cycle, write applied at release
      unique case (cur.bus)
         BUS_IDLE: begin
            if (req) begin
               next_cur.bus = BUS_ACK;
               next_cur.resp = mapped(avs_address) ? RESP_OKAY : RESP_DECODEERROR;
               next_cur.rdata = READ_UNMAPPED;
               if (hit(avs_address, ADDR_CONTROL)) begin
                  next_cur.rdata[CTL_W-1:0] = cur.ctl;
               end else if (hit(avs_address, ADDR_CAPS)) begin
                  next_cur.rdata[CAP_CRS_VIS] = CRS_SUPPORTED;
               end else if (hit(avs_address, ADDR_STATUS)) begin
                  next_cur.rdata[STS_RID_LSB +: RID_W] = cur.pme_rid;
                  next_cur.rdata[STS_PME] = cur.pme_status;
                  next_cur.rdata[STS_PENDING] = pending;
               end
            end
         end
         BUS_ACK: begin
            next_cur.bus = BUS_IDLE;
         end
      endcase

      // Control write; retry visibility stays zero where unsupported
      if (wr_now && hit(avs_address, ADDR_CONTROL) && avs_byteenable[0]) begin
         next_cur.ctl = avs_writedata[CTL_W-1:0];
         next_cur.ctl[CTL_CRS_VIS] = avs_writedata[CTL_CRS_VIS] & CRS_SUPPORTED;
      end

      // Status clear comes first so that a hardware set in the same cycle wins
      if (w1c) begin
         next_cur.pme_status = 1'b0;
      end

      // Queue bookkeeping
      if (push) begin
         next_cur.tail = (cur.tail == QUEUE_LAST) ? '0 : cur.tail + 1'b1;
      end
      if (fetch_start) begin
         next_cur.head = (cur.head == QUEUE_LAST) ? '0 : cur.head + 1'b1;
      end
      next_cur.count = cur.count + (AW+1)'(push) - (AW+1)'(fetch_start);
      next_cur.pme_drop = pme_msg_valid & ~direct_load & ~push;

      // Delivery: straight in when idle, else from the queue after one read cycle
      unique case (cur.pme)
         PME_IDLE: begin
            if (direct_load) begin
               next_cur.pme_status = 1'b1;
               next_cur.pme_rid = pme_msg_rid;
            end else if (fetch_start) begin
               next_cur.pme = PME_FETCH;
            end
         end
         PME_FETCH: begin
            next_cur.pme = PME_IDLE;
            next_cur.pme_status = 1'b1;
            next_cur.pme_rid = mem_rdata;
         end
      endcase

      // Interrupt on delivery, or on enabling while status already stands
      next_cur.pme_irq = ((direct_load | fetch_done) & cur.ctl[CTL_PME_IE])
         | (~cur.ctl[CTL_PME_IE] & next_cur.ctl[CTL_PME_IE] & cur.pme_status);

      // Retry completions go to software or back to the port for reissue
      next_cur.crs_sw = crs_cpl_valid & cur.ctl[CTL_CRS_VIS];
      next_cur.crs_retry = crs_cpl_valid & ~cur.ctl[CTL_CRS_VIS];
   end

   // ==========================================================
   // State register
   // Asynchronous clear brings every enable up off and the queue empty
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         cur <= '0;
         cur.bus <= BUS_IDLE;
         cur.pme <= PME_IDLE;
         cur.ctl <= CONTROL_RESET;
         cur.pme_rid <= RID_RESET;
      end else begin
         cur <= next_cur;
      end
   end

   // Outputs straight from flip-flops
   assign avs_readdata = cur.rdata;
   assign avs_response = cur.resp;
   assign pme_interrupt = cur.pme_irq;
   assign pme_dropped = cur.pme_drop;
   assign crs_to_software = cur.crs_sw;
   assign crs_retry_internal = cur.crs_retry;

   // ==========================================================
   // Checks
   // Most checks look at the registered image one edge after its cause
   AST_SE_COR: assert property (@(posedge mclk) disable iff (!arst_n)
      (hier_err[SEV_COR] | port_err[SEV_COR]) && cur.ctl[CTL_SE_COR] |=> system_error && system_error_sev[SEV_COR])
      else $error("correctable error did not raise system error");

   AST_SE_NONFATAL: assert property (@(posedge mclk) disable iff (!arst_n)
      (hier_err[SEV_NONFATAL] | port_err[SEV_NONFATAL]) && cur.ctl[CTL_SE_NONFATAL]
      |=> system_error_sev[SEV_NONFATAL])
      else $error("non-fatal error did not raise system error");

   AST_SE_FATAL: assert property (@(posedge mclk) disable iff (!arst_n)
      (hier_err[SEV_FATAL] | port_err[SEV_FATAL]) && cur.ctl[CTL_SE_FATAL] |=> system_error_sev[SEV_FATAL])
      else $error("fatal error did not raise system error");

   AST_SE_QUIET: assert property (@(posedge mclk) disable iff (!arst_n)
      ((hier_err | port_err | (EVENT_COLLECTOR ? rcie_err : '0)) & cur.ctl[CTL_SE_FATAL:CTL_SE_COR]) == '0
      |=> !system_error)
      else $error("system error without an enabled source");

   AST_CTL_RESET: assert property (@(posedge mclk) disable iff (!arst_n)
      !cur.out_of_reset |-> cur.ctl == CONTROL_RESET && !cur.pme_status)
      else $error("control not clear after reset");

   AST_PME_IRQ: assert property (@(posedge mclk) disable iff (!arst_n)
      (direct_load | fetch_done) && cur.ctl[CTL_PME_IE] |=> pme_interrupt && cur.pme_status)
      else $error("no interrupt on event delivery");

   AST_PME_IRQ_LATE: assert property (@(posedge mclk) disable iff (!arst_n)
      $rose(cur.ctl[CTL_PME_IE]) && $past(cur.pme_status) |-> pme_interrupt)
      else $error("no interrupt when enabled with status set");

   AST_CRS_GATE: assert property (@(posedge mclk) disable iff (!arst_n)
      crs_to_software |-> $past(crs_cpl_valid) && $past(cur.ctl[CTL_CRS_VIS]))
      else $error("retry status passed while visibility disabled");

   AST_CRS_TIED: assert property (@(posedge mclk) disable iff (!arst_n)
      !CRS_SUPPORTED |-> !cur.ctl[CTL_CRS_VIS])
      else $error("retry visibility enable set without support");

   AST_CAPS: assert property (@(posedge mclk) disable iff (!arst_n)
      cur.bus == BUS_ACK && avs_read && hit(avs_address, ADDR_CAPS) |-> avs_readdata[CAP_CRS_VIS] == CRS_SUPPORTED)
      else $error("capability bit wrong");

   AST_RID_LOAD: assert property (@(posedge mclk) disable iff (!arst_n)
      direct_load |=> cur.pme_rid == $past(pme_msg_rid))
      else $error("requester identity not captured");

   AST_W1C_ZERO: assert property (@(posedge mclk) disable iff (!arst_n)
      cur.pme_status && wr_now && hit(avs_address, ADDR_STATUS) && !avs_writedata[STS_PME] |=> cur.pme_status)
      else $error("writing zero cleared event status");

   AST_RID_HOLD: assert property (@(posedge mclk) disable iff (!arst_n)
      cur.pme_status && !w1c |=> $stable(cur.pme_rid) && cur.pme_status)
      else $error("captured requester overwritten while status set");

   AST_PENDING: assert property (@(posedge mclk) disable iff (!arst_n)
      cur.bus == BUS_IDLE && avs_read && hit(avs_address, ADDR_STATUS) && pending
      |=> avs_readdata[STS_PENDING] && avs_readdata[STS_PME])
      else $error("pending bit not reported");

   AST_REDELIVER: assert property (@(posedge mclk) disable iff (!arst_n)
      w1c && cur.pme_status && cur.count != '0 |=> !cur.pme_status ##2 cur.pme_status)
      else $error("queued event not delivered after clear");

   AST_PENDING_CLEAR: assert property (@(posedge mclk) disable iff (!arst_n)
      cur.count == '0 |-> !pending)
      else $error("pending set with empty queue");

   AST_OVERFLOW: assert property (@(posedge mclk) disable iff (!arst_n)
      pme_msg_valid && cur.count == QUEUE_FULL && !fetch_start |=> pme_dropped && cur.count == QUEUE_FULL
      && $stable(cur.tail))
      else $error("full queue accepted or corrupted an entry");

   AST_CRS_WRITE: assert property (@(posedge mclk) disable iff (!arst_n)
      wr_now && hit(avs_address, ADDR_CONTROL) && avs_byteenable[0]
      |=> cur.ctl[CTL_CRS_VIS] == ($past(avs_writedata[CTL_CRS_VIS]) && CRS_SUPPORTED))
      else $error("retry visibility enable wrong after control write");

   AST_CRS_RETRY: assert property (@(posedge mclk) disable iff (!arst_n)
      crs_cpl_valid && !cur.ctl[CTL_CRS_VIS] |=> crs_retry_internal && !crs_to_software)
      else $error("retry status not kept inside while visibility disabled");

   AST_IRQ_STATUS: assert property (@(posedge mclk) disable iff (!arst_n)
      pme_interrupt |-> cur.pme_status)
      else $error("interrupt without event status");

   AST_DELIVER_RID: assert property (@(posedge mclk) disable iff (!arst_n)
      fetch_done |=> cur.pme_status && cur.pme_rid == $past(mem_rdata))
      else $error("queued requester not loaded on delivery");

   AST_QUEUE_BOUND: assert property (@(posedge mclk) disable iff (!arst_n)
      cur.count <= QUEUE_FULL)
      else $error("queue count beyond its depth");
endmodule

// File: pme_msg_source.sv
// Downstream message source: power-event and retry-completion messages
`timescale 1ns/100ps
module pme_msg_source (
   input wire logic mclk,
   output logic pme_msg_valid,
   output logic [15:0] pme_msg_rid,
   output logic crs_cpl_valid
);
   // ==========================================================
   // Idle values; a released id line shows the inverse so a stale id never looks valid
   initial begin
      pme_msg_valid = 1'b0;
      pme_msg_rid = 16'h5a5a;
      crs_cpl_valid = 1'b0;
   end

   // ==========================================================
   // One message per call, a single-cycle pulse launched after an edge
   task automatic send_pme(input logic [15:0] rid);
      @(posedge mclk);
      pme_msg_valid <= 1'b1;
      pme_msg_rid <= rid;
      @(posedge mclk);
      pme_msg_valid <= 1'b0;
      pme_msg_rid <= ~rid; // Released line shows inverse
   endtask

   // Retry completion arriving from below
   task automatic send_crs();
      @(posedge mclk);
      crs_cpl_valid <= 1'b1;
      @(posedge mclk);
      crs_cpl_valid <= 1'b0;
   endtask
endmodule

// File: root_port_error_pme_control_test.sv
// Self-checking bench for the root-port error and power-event register block
`timescale 1ns/100ps
module root_port_error_pme_control_test;
   import root_port_pkg::*;

   typedef struct packed {
      logic [2:0] en;
      logic [2:0] h;
      logic [2:0] p;
      logic [2:0] r;
      logic [2:0] exp;
   } err_row_t;

   logic mclk;
   logic arst_n;
   logic [9:0] avs_address;
   logic avs_read;
   logic avs_write;
   logic [31:0] avs_writedata;
   logic [3:0] avs_byteenable;
   logic [31:0] avs_readdata;
   logic [1:0] avs_response;
   logic avs_waitrequest;
   logic [2:0] hier_err;
   logic [2:0] port_err;
   logic [2:0] rcie_err;
   logic system_error;
   logic [2:0] system_error_sev;
   logic pme_msg_valid;
   logic [15:0] pme_msg_rid;
   logic pme_dropped;
   logic pme_interrupt;
   logic crs_cpl_valid;
   logic crs_to_software;
   logic crs_retry_internal;
   int errors = 0;
   int n_checks = 0;
   int cycles = 0;
   int n_irq = 0;
   int n_drop = 0;
   logic [31:0] d;
   logic [1:0] rsp;
   // Severity table: enables, hierarchy, port, endpoint, expected per-severity
   err_row_t rows [8] = '{
      '{3'h1, 3'h1, 3'h0, 3'h0, 3'h1}, '{3'h1, 3'h6, 3'h0, 3'h0, 3'h0},
      '{3'h2, 3'h0, 3'h2, 3'h0, 3'h2}, '{3'h4, 3'h4, 3'h0, 3'h0, 3'h4},
      '{3'h3, 3'h4, 3'h1, 3'h0, 3'h1}, '{3'h4, 3'h0, 3'h0, 3'h4, 3'h4},
      '{3'h7, 3'h0, 3'h0, 3'h3, 3'h3}, '{3'h0, 3'h7, 3'h7, 3'h7, 3'h0}};

   // ==========================================================
   // Design and far-side model
   root_port_error_pme_control #(.EVENT_COLLECTOR(1'b1)) u_dut (
      .mclk(mclk), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_response(avs_response), .avs_waitrequest(avs_waitrequest),
      .hier_err(hier_err), .port_err(port_err), .rcie_err(rcie_err), .system_error(system_error),
      .system_error_sev(system_error_sev), .pme_msg_valid(pme_msg_valid), .pme_msg_rid(pme_msg_rid),
      .pme_dropped(pme_dropped), .pme_interrupt(pme_interrupt), .crs_cpl_valid(crs_cpl_valid),
      .crs_to_software(crs_to_software), .crs_retry_internal(crs_retry_internal));

   pme_msg_source u_src (.mclk(mclk), .pme_msg_valid(pme_msg_valid), .pme_msg_rid(pme_msg_rid),
      .crs_cpl_valid(crs_cpl_valid));

   // ==========================================================
   // Clock, pulse counters and hang guard
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   // Pulses are one cycle wide, so counting at each edge misses none
   always @(posedge mclk) begin
      cycles++;
      if (pme_interrupt === 1'b1) n_irq++;
      if (pme_dropped === 1'b1) n_drop++;
      if (cycles >= 5000) begin
         errors++;
         print_verdict();
      end
   end

   // ==========================================================
   // Shared tasks
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Request held until waitrequest is seen low at an edge
   task automatic bus_write(input logic [9:0] a, input logic [31:0] wd, input logic [3:0] be);
      @(posedge mclk);
      avs_address <= a;
      avs_writedata <= wd;
      avs_byteenable <= be;
      avs_write <= 1'b1;
      do @(posedge mclk); while (avs_waitrequest !== 1'b0);
      avs_write <= 1'b0;
   endtask

   task automatic bus_read(input logic [9:0] a, output logic [31:0] rd, output logic [1:0] rr);
      @(posedge mclk);
      avs_address <= a;
      avs_read <= 1'b1;
      do @(posedge mclk); while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      rr = avs_response;
      avs_read <= 1'b0;
   endtask

   // Clear event status, then wait three edges, one more than the two-edge redelivery time
   task automatic clear_status();
      bus_write(ADDR_STATUS, 32'h0001_0000, 4'h4);
      repeat (3) @(posedge mclk);
   endtask

   task automatic end_test(input string name);
      $display("test %s done, checks %0d errors %0d", name, n_checks, errors);
   endtask

   task automatic print_verdict();
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      arst_n = 1'b0;
      avs_address = 10'h000;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0000_0000;
      avs_byteenable = 4'h0;
      hier_err = 3'h0;
      port_err = 3'h0;
      rcie_err = 3'h0;
      repeat (8) @(posedge mclk);
      arst_n <= 1'b1;
      // Reset values, read-only capability, unmapped place
      bus_read(ADDR_CONTROL, d, rsp);
      check("control reset", d, 32'h0000_0000);
      bus_read(ADDR_STATUS, d, rsp);
      check("status reset", d, 32'h0000_0000);
      bus_read(ADDR_CAPS, d, rsp);
      check("caps retry bit", d, 32'h0000_0001);
      bus_write(ADDR_CAPS, 32'h0000_0000, 4'hf);
      bus_read(ADDR_CAPS, d, rsp);
      check("caps after write", d, 32'h0000_0001);
      bus_read(10'h3fc, d, rsp);
      check("unmapped data", d, 32'h0000_0000);
      check("unmapped response", {30'h0, rsp}, 32'h0000_0003);
      bus_write(ADDR_CONTROL, 32'hffff_ffff, 4'hf);
      bus_read(ADDR_CONTROL, d, rsp);
      check("control all ones", d, 32'h0000_001f);
      end_test("registers");
      // Ordinary severity cases from the table
      foreach (rows[i]) begin
         bus_write(ADDR_CONTROL, {29'h0, rows[i].en}, 4'h1);
         @(posedge mclk);
         hier_err <= rows[i].h;
         port_err <= rows[i].p;
         rcie_err <= rows[i].r;
         @(posedge mclk);
         hier_err <= 3'h0;
         port_err <= 3'h0;
         rcie_err <= 3'h0;
         @(negedge mclk);
         check("severity", {29'h0, system_error_sev}, {29'h0, rows[i].exp});
         check("system error", {31'h0, system_error}, {31'h0, |rows[i].exp});
      end
      end_test("severity");
      // Retry completion routing both ways
      bus_write(ADDR_CONTROL, 32'h0000_0010, 4'h1);
      u_src.send_crs();
      @(negedge mclk);
      check("retry to software", {crs_to_software, crs_retry_internal}, 32'h0000_0002);
      bus_write(ADDR_CONTROL, 32'h0000_0000, 4'h1);
      u_src.send_crs();
      @(negedge mclk);
      check("retry kept inside", {crs_to_software, crs_retry_internal}, 32'h0000_0001);
      end_test("retry");
      // Event capture, hold while set, write-zero, redelivery
      bus_write(ADDR_CONTROL, 32'h0000_0008, 4'h1);
      u_src.send_pme(16'ha001);
      @(negedge mclk);
      check("event interrupt", {31'h0, pme_interrupt}, 32'h0000_0001);
      u_src.send_pme(16'hb002);
      u_src.send_pme(16'hc003);
      bus_read(ADDR_STATUS, d, rsp);
      check("held id pending", d, 32'h0003_a001);
      bus_write(ADDR_STATUS, 32'h0000_0000, 4'hf);
      bus_read(ADDR_STATUS, d, rsp);
      check("write zero no effect", d, 32'h0003_a001);
      clear_status();
      bus_read(ADDR_STATUS, d, rsp);
      check("second delivery", d, 32'h0003_b002);
      clear_status();
      bus_read(ADDR_STATUS, d, rsp);
      check("last delivery", d, 32'h0001_c003);
      clear_status();
      bus_read(ADDR_STATUS, d, rsp);
      check("status cleared", d, 32'h0000_c003);
      check("interrupt count", n_irq, 32'h0000_0003);
      end_test("events");
      // Queue full with interrupts off, order kept on drain
      bus_write(ADDR_CONTROL, 32'h0000_0000, 4'h1);
      for (int k = 0; k < 6; k++) u_src.send_pme(16'hd000 + 16'(k));
      repeat (2) @(negedge mclk); // Drop pulse follows the last edge and is counted one edge later
      check("drop count", n_drop, 32'h0000_0001);
      for (int k = 1; k < 5; k++) begin
         clear_status();
         bus_read(ADDR_STATUS, d, rsp);
         check("drain order", d, {14'h0, k < 4, 1'b1, 16'hd000 + 16'(k)});
      end
      // Enable raised while status already set
      bus_write(ADDR_CONTROL, 32'h0000_0008, 4'h1);
      repeat (2) @(posedge mclk);
      check("late enable interrupt", n_irq, 32'h0000_0004);
      end_test("queue");
      // Reset in mid-run clears everything
      @(posedge mclk);
      arst_n <= 1'b0;
      repeat (2) @(posedge mclk);
      arst_n <= 1'b1;
      bus_read(ADDR_CONTROL, d, rsp);
      check("control after reset", d, 32'h0000_0000);
      bus_read(ADDR_STATUS, d, rsp);
      check("status after reset", d, 32'h0000_0000);
      end_test("reset");
      print_verdict();
   end
endmodule
